// ### osc_ctl.sv
`timescale 1ns/1ps
`include "osc_ctl_params.svh"
// Function
// - trim is signed, 0.375% per code step
// - bit13 picks aux reference else PLL
// - aux mode: ext, crystal, fast crystal, off
// - aux divider 1..64 doubling, 000 is 256
// - bit7 picks primary else aux reference
// - unimplemented bits read as zero
// - source 010 primary, 011 primary with PLL
// - primary mode: ext, medium, high, off
// - clock held until 1024 oscillator cycles
// - count only after valid oscillator levels
// - restart count on every oscillator restart
// - PLL mode also waits for PLL lock
// - pin2 outputs cycle clock or general I/O
// - primary off frees pin1 for I/O
// - crystal modes dedicate both pins
// - external mode bypasses amp, pin1 clocks
// - registers reset only on power-on reset
module osc_ctl
  import osc_ctl_pkg::*;
(
  input  wire logic                      clk,           // system clock, 125 MHz
  input  wire logic                      rst,           // power-on reset, async high
  input  wire osc_ctl_pkg::osc_config_t  config_bits,   // nonvolatile configuration
  input  wire logic                      osc_level_ok,  // oscillator amplitude valid
  input  wire logic                      osc_edge,      // first_oscillator_pin clock level
  input  wire logic                      osc_restart,   // brown-out or wake from sleep
  input  wire logic                      pll_locked,    // PLL lock status
  input  wire logic                      cycle_clk,     // instruction-cycle clock level
  input  wire logic                      aux_osc_clk,   // auxiliary oscillator level
  input  wire logic                      pll_clk,       // PLL output level
  input  wire logic                      primary_clk,   // primary oscillator level
  input  wire logic                      pin2_in,       // second_oscillator_pin input
  input  wire logic                      s_axi_awvalid, // write address valid
  output logic                           s_axi_awready, // write address ready
  input  wire logic [11:0]               s_axi_awaddr,  // write address
  input  wire logic                      s_axi_wvalid,  // write data valid
  output logic                           s_axi_wready,  // write data ready
  input  wire logic [31:0]               s_axi_wdata,   // write data
  input  wire logic [3:0]                s_axi_wstrb,   // write strobes
  output logic                           s_axi_bvalid,  // write response valid
  input  wire logic                      s_axi_bready,  // write response ready
  output logic [1:0]                     s_axi_bresp,   // write response
  input  wire logic                      s_axi_arvalid, // read address valid
  output logic                           s_axi_arready, // read address ready
  input  wire logic [11:0]               s_axi_araddr,  // read address
  output logic                           s_axi_rvalid,  // read data valid
  input  wire logic                      s_axi_rready,  // read data ready
  output logic [31:0]                    s_axi_rdata,   // read data
  output logic [1:0]                     s_axi_rresp,   // read response
  output logic signed [5:0]              rc_trim_field, // signed trim to rc oscillator
  output logic                           clock_ready,   // system clock released
  output logic                           aux_clk_out,   // divided auxiliary clock
  output logic                           pin1_oe,       // pin1 claimed by oscillator
  output logic                           pin2_out,      // second_oscillator_pin drive
  output logic                           pin2_oe,       // second_oscillator_pin enable
  output osc_ctl_pkg::pin_mux_t          pin_mux        // pin and amplifier setup
);
  logic [15:0]                rc_tuning;
  logic [15:0]                auxiliary_clock_control;
  logic [31:0]                pin_io;
  logic                       aw_held;
  logic                       w_held;
  logic [11:0]                aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic [1:0]                 lvl_s1;
  logic [1:0]                 lvl_s2;
  logic [2:0]                 edge_s;
  logic [2:0]                 src_s1;
  logic [2:0]                 src_s2;
  logic [1:0]                 pin2_s;
  logic                       cyc_s1;
  logic                       cyc_s2;
  logic [`STARTUP_WIDTH-1:0]  startup_counter;
  logic                       count_done;
  logic                       cfg_pll;
  logic                       cfg_primary;
  logic [7:0]                 aux_div_count;
  logic                       aux_src_level;
  logic                       aux_src_prev;
  logic [7:0]                 next_aux_div_count;
  logic [7:0]                 aux_half;
  logic [15:0]                wr_word;
  prim_mode_t                 pmode;
  aux_mode_t                  amode;
  pin_mux_t                   next_pin_mux;

  // AXI4-Lite write: address and data taken in either order
  wire write_go = aw_held && w_held && !s_axi_bvalid;
  wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (write_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `RC_TUNING_ADDR || aw_addr == `AUX_CLOCK_CTRL_ADDR
                        || aw_addr == `PIN_IO_ADDR || aw_addr == `OSC_STATUS_ADDR)
                        ? 2'h0 : 2'h2;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_word = w_data[15:0];

  // only power-on reset clears these; osc_restart leaves them alone
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rc_tuning               <= `RC_TUNING_RESET;
      auxiliary_clock_control <= `AUX_CLOCK_CTRL_RESET;
      pin_io                  <= 32'h0000_0000;
    end
    else if (write_go)
    begin
      if (aw_addr == `RC_TUNING_ADDR)
        rc_tuning <= (rc_tuning & ~wmask) | (wr_word & wmask & `RC_TUNING_MASK);
      if (aw_addr == `AUX_CLOCK_CTRL_ADDR)
        auxiliary_clock_control <= (auxiliary_clock_control & ~wmask)
                                   | (wr_word & wmask & `AUX_CLOCK_CTRL_MASK);
      if (aw_addr == `PIN_IO_ADDR && w_strb[0])
        pin_io[1:0] <= w_data[1:0];
    end
  end

  // AXI4-Lite read, one word per access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `RC_TUNING_ADDR:      s_axi_rdata <= {16'h0000, rc_tuning};
          `AUX_CLOCK_CTRL_ADDR: s_axi_rdata <= {16'h0000, auxiliary_clock_control};
          `OSC_STATUS_ADDR:     s_axi_rdata <= {21'h0, count_done, pll_locked, 1'b0,
                                                startup_counter[`STARTUP_WIDTH-1:2]};
          `PIN_IO_ADDR:         s_axi_rdata <= {29'h0, pin2_s[1], pin_io[1:0]};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // pin levels cross into clk through two flops before use
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lvl_s1    <= 2'h0;
      lvl_s2    <= 2'h0;
      edge_s    <= 3'h0;
      src_s1    <= 3'h0;
      src_s2    <= 3'h0;
      aux_src_prev <= 1'b0;
      pin2_s    <= 2'h0;
      cyc_s1    <= 1'b0;
      cyc_s2    <= 1'b0;
    end
    else
    begin
      lvl_s1    <= {osc_restart, osc_level_ok};
      lvl_s2    <= lvl_s1;
      edge_s    <= {edge_s[1:0], osc_edge};
      src_s1    <= {primary_clk, aux_osc_clk, pll_clk};
      src_s2    <= src_s1;
      aux_src_prev <= aux_src_level;
      pin2_s    <= {pin2_s[0], pin2_in};
      cyc_s1    <= cycle_clk;
      cyc_s2    <= cyc_s1;
    end
  end

  assign pmode       = prim_mode_t'(config_bits.primary_mode_config);
  assign cfg_pll     = (config_bits.initial_source == `SRC_PRIMARY_PLL);
  assign cfg_primary = (config_bits.initial_source == `SRC_PRIMARY) || cfg_pll;
  wire osc_enabled   = cfg_primary && (pmode != prim_off);
  wire osc_edge_rise = edge_s[1] && !edge_s[2];

  // start-up counter; the release edge is the 1024th counted oscillator cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      startup_counter <= '0;
      count_done      <= 1'b0;
    end
    else if (!osc_enabled || lvl_s2[1])
    begin
      startup_counter <= '0;
      count_done      <= 1'b0;
    end
    else if (lvl_s2[0] && osc_edge_rise && !count_done)
    begin
      startup_counter <= startup_counter + 1'b1;
      if (startup_counter == `STARTUP_WIDTH'(`STARTUP_CYCLES - 1))
        count_done <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      clock_ready <= 1'b0;
    else
      clock_ready <= count_done && (!cfg_pll || pll_locked);
  end

  // auxiliary clock: pick source, then divide in clk by counting source edges
  assign amode = aux_mode_t'(auxiliary_clock_control[`AUX_MODE_MSB:`AUX_MODE_LSB]);
  wire aux_ref = auxiliary_clock_control[`AUX_REF_SEL_BIT]
                 ? src_s2[2] : (amode != aux_off && src_s2[1]);
  always_comb
  begin
    aux_src_level = auxiliary_clock_control[`AUX_DIV_SRC_BIT] ? aux_ref : src_s2[0];
    case (auxiliary_clock_control[`AUX_DIV_MSB:`AUX_DIV_LSB])
      3'h7:    aux_half = 8'h00;
      3'h6:    aux_half = 8'h01;
      3'h5:    aux_half = 8'h02;
      3'h4:    aux_half = 8'h04;
      3'h3:    aux_half = 8'h08;
      3'h2:    aux_half = 8'h10;
      3'h1:    aux_half = 8'h20;
      default: aux_half = 8'h80;
    endcase
    next_aux_div_count = aux_div_count + 8'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aux_div_count <= 8'h00;
      aux_clk_out   <= 1'b0;
    end
    else if (aux_src_level && !aux_src_prev)
    begin
      // divide-by-1 passes each source edge as a high pulse
      if (aux_half == 8'h00)
        aux_clk_out <= 1'b1;
      else if (next_aux_div_count >= aux_half)
      begin
        aux_div_count <= 8'h00;
        aux_clk_out   <= !aux_clk_out;
      end
      else
        aux_div_count <= next_aux_div_count;
    end
    else if (aux_half == 8'h00 && !aux_src_level)
      aux_clk_out <= 1'b0;
  end

  assign rc_trim_field = signed'(rc_tuning[`TRIM_MSB:`TRIM_LSB]);

  // pin function mux
  always_comb
  begin
    next_pin_mux.amp_bypass   = (pmode == prim_external);
    next_pin_mux.amp_on       = (pmode == prim_medium) || (pmode == prim_high);
    next_pin_mux.pin1_is_io   = (pmode == prim_off);
    next_pin_mux.pin2_clk_out = !next_pin_mux.amp_on
                                && config_bits.second_pin_function_config;
    next_pin_mux.pin2_is_io   = !next_pin_mux.amp_on
                                && !config_bits.second_pin_function_config;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_mux  <= '0;
      pin1_oe  <= 1'b0;
      pin2_out <= 1'b0;
      pin2_oe  <= 1'b0;
    end
    else
    begin
      pin_mux  <= next_pin_mux;
      pin1_oe  <= next_pin_mux.amp_on;
      pin2_out <= next_pin_mux.pin2_clk_out ? cyc_s2 : pin_io[0];
      pin2_oe  <= next_pin_mux.pin2_clk_out || next_pin_mux.amp_on
                  || (next_pin_mux.pin2_is_io && pin_io[1]);
    end
  end
endmodule

// ### osc_ctl_params.svh
`ifndef OSC_CTL_PARAMS_SVH
`define OSC_CTL_PARAMS_SVH
`define RC_TUNING_ADDR        12'h000
`define AUX_CLOCK_CTRL_ADDR   12'h004
`define OSC_STATUS_ADDR       12'h008
`define PIN_IO_ADDR           12'h00c
`define TRIM_LSB              0
`define TRIM_MSB              5
`define AUX_DIV_SRC_BIT       13
`define AUX_MODE_MSB          12
`define AUX_MODE_LSB          11
`define AUX_DIV_MSB           10
`define AUX_DIV_LSB           8
`define AUX_REF_SEL_BIT       7
`define RC_TUNING_RESET       16'h0000
`define AUX_CLOCK_CTRL_RESET  16'h0000
`define RC_TUNING_MASK        16'h003f
`define AUX_CLOCK_CTRL_MASK   16'h3f80
`define STARTUP_CYCLES        1024
`define STARTUP_WIDTH         10
`define SRC_PRIMARY           3'h2
`define SRC_PRIMARY_PLL       3'h3
`endif

// ### osc_ctl_pkg.sv
package osc_ctl_pkg;
  typedef enum logic [1:0]
  {
    prim_external = 2'h0,
    prim_medium   = 2'h1,
    prim_high     = 2'h2,
    prim_off      = 2'h3
  } prim_mode_t;
  typedef enum logic [1:0]
  {
    aux_off       = 2'h0,
    aux_high      = 2'h1,
    aux_crystal   = 2'h2,
    aux_external  = 2'h3
  } aux_mode_t;
  typedef struct packed
  {
    logic        pin1_is_io;
    logic        pin2_is_io;
    logic        pin2_clk_out;
    logic        amp_on;
    logic        amp_bypass;
  } pin_mux_t;
  typedef struct packed
  {
    logic [2:0]  initial_source;
    prim_mode_t  primary_mode_config;
    logic        second_pin_function_config;
  } osc_config_t;
endpackage

// ### osc_ctl_monitor.sv
`timescale 1ns/1ps
`include "osc_ctl_params.svh"
module osc_ctl_monitor
  import osc_ctl_pkg::*;
(
  input wire logic                     clk,          // system clock
  input wire logic                     rst,          // power-on reset
  input wire osc_ctl_pkg::osc_config_t config_bits,  // configuration
  input wire logic                     osc_level_ok, // amplitude valid
  input wire logic                     osc_edge,     // oscillator level
  input wire logic                     osc_restart,  // restart request
  input wire logic                     pll_locked,   // lock status
  input wire logic                     clock_ready,  // clock released
  input wire logic                     pin1_oe,      // pin1 claimed
  input wire osc_ctl_pkg::pin_mux_t    pin_mux       // pin setup
);
  import osc_ctl_pkg::*;
  logic        prev_edge;
  int unsigned edges;
  prim_mode_t  m;
  assign m = config_bits.primary_mode_config;
  // raw edges: never fewer than the design sees behind its synchronisers, except after osc_level_ok falls, which only pauses the design
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      prev_edge <= 1'b0;
      edges     <= 0;
    end
    else
    begin
      prev_edge <= osc_edge;
      if (!osc_level_ok || osc_restart)
        edges <= 0;
      else if (osc_edge && !prev_edge)
        edges <= edges + 1;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence crystal; m == prim_medium || m == prim_high; endsequence
  sequence pin2_free; m == prim_external || m == prim_off; endsequence
  a_startup_full_count: assert property (
    $rose(clock_ready) |-> edges >= `STARTUP_CYCLES) else $error("clock released early");
  a_ready_needs_lock: assert property (
    clock_ready && config_bits.initial_source == `SRC_PRIMARY_PLL |-> $past(pll_locked))
    else $error("ready without lock");
  a_source_not_primary: assert property (
    !(config_bits.initial_source inside {`SRC_PRIMARY, `SRC_PRIMARY_PLL})
    |-> ##[1:3] !clock_ready) else $error("ready with other source");
  a_mode_off_clears: assert property (m == prim_off |-> ##[1:3] !clock_ready)
    else $error("ready while oscillator off");
  a_restart_clears: assert property ($rose(osc_restart) |-> ##[1:6] !clock_ready)
    else $error("restart did not clear ready");
  a_crystal_pins: assert property (crystal |=> pin1_oe && !pin_mux.pin1_is_io
    && !pin_mux.pin2_is_io && !pin_mux.pin2_clk_out) else $error("crystal pins not owned");
  a_external_bypass: assert property (
    m == prim_external |=> pin_mux.amp_bypass && !pin1_oe) else $error("no bypass");
  a_off_frees_pin1: assert property (
    m == prim_off |=> pin_mux.pin1_is_io && !pin_mux.amp_on) else $error("pin1 held");
  a_pin2_function: assert property (pin2_free |=>
    pin_mux.pin2_clk_out == $past(config_bits.second_pin_function_config)
    && pin_mux.pin2_is_io != pin_mux.pin2_clk_out) else $error("pin2 function wrong");
endmodule

bind osc_ctl osc_ctl_monitor mon (.*);

// ### osc_source_model.sv
`timescale 1ns/1ps
module osc_source_model
#(
  parameter int HALF_NS = 16,  // half period of the source
  parameter int RAMP_NS = 131  // amplitude build-up, off the clk grid
)
(
  input  wire logic run,      // source powered
  output logic      osc_out,  // level on first_oscillator_pin
  output logic      level_ok  // amplitude past input thresholds
);
  initial
  begin
    osc_out  = 1'b0;
    level_ok = 1'b0;
    forever
    begin
      wait (run);
      #RAMP_NS level_ok = 1'b1;
      while (run)
        #HALF_NS osc_out = ~osc_out;
      osc_out  = 1'b0;
      level_ok = 1'b0;
    end
  end
endmodule

// ### osc_ctl_test.sv
`timescale 1ns/1ps
`include "osc_ctl_params.svh"
module osc_ctl_test;
  import osc_ctl_pkg::*;
  logic        clk, rst, osc_restart, pll_locked, cycle_clk, pin2_in, osc_run, fr, prev_aux;
  logic        aux_osc_clk, pll_clk, primary_clk, clock_ready, aux_clk_out, pin1_oe;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pin2_out, pin2_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic signed [5:0] rc_trim_field;
  wire         osc_edge, osc_level_ok;
  osc_config_t config_bits;
  pin_mux_t    pin_mux;
  int          fails = 0, n_checks = 0, cyc = 0, aux_rises = 0, c0, i;
  logic [15:0] tvals [3] = '{16'h001f, 16'h0020, 16'hffc1};
  logic [15:0] actl [8] = '{16'h3700, 16'h2f00, 16'h3f00, 16'h2700, 16'h3600, 16'h3000,
                            16'h3780, 16'h1700};
  int          aexp [8] = '{80, 80, 80, 0, 40, 0, 40, 20};

  osc_ctl dut (.*);
  osc_source_model src (.run(osc_run), .osc_out(osc_edge), .level_ok(osc_level_ok));

  always #4 clk = ~clk;
  // sources kept off the clk edges so their sampling never races
  initial #1 forever #32 aux_osc_clk = ~aux_osc_clk;
  initial #1 forever #64 primary_clk = ~primary_clk;
  initial #1 forever #128 pll_clk = ~pll_clk;

  always @(posedge clk)
  begin
    prev_aux <= aux_clk_out;
    if (aux_clk_out && !prev_aux)
      aux_rises <= aux_rises + 1;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    resp    = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // a fixed wait short of the full count, then a bounded wait for release
  task automatic settle(input logic exp);
    repeat (4000) @(posedge clk);
    chk(clock_ready, 0);
    for (c0 = 0; c0 < 400 && clock_ready !== 1'b1; c0++)
      @(posedge clk);
    chk(clock_ready, exp);
  endtask

  task automatic restart;
    osc_restart <= 1'b1;
    @(posedge clk);
    osc_restart <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {clk, rst, osc_restart, pll_locked, cycle_clk, pin2_in, osc_run} = 7'h20;
    {aux_osc_clk, pll_clk, primary_clk} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    config_bits = '{`SRC_PRIMARY, prim_external, 1'b0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`RC_TUNING_ADDR);
    chk(rd_data, 0);
    rd(`AUX_CLOCK_CTRL_ADDR);
    chk(rd_data, 0);
    wr(12'h010, 32'hffffffff);
    chk(resp, 2);
    rd(12'h010);
    chk({rd_data[29:0], resp}, 2);
    for (i = 0; i < 3; i++)
    begin
      wr(`RC_TUNING_ADDR, {16'h0, tvals[i]});
      rd(`RC_TUNING_ADDR);
      chk(rd_data, {26'h0, tvals[i][5:0]});
      chk(32'(rc_trim_field), 32'(signed'(tvals[i][5:0])));
    end
    wr(`AUX_CLOCK_CTRL_ADDR, 32'h0000ffff);
    rd(`AUX_CLOCK_CTRL_ADDR);
    chk(rd_data, 32'h3f80);
    osc_run <= 1'b1;
    settle(1);
    restart;
    chk(clock_ready, 0);
    settle(1);
    restart;
    config_bits.initial_source <= `SRC_PRIMARY_PLL;
    settle(0);
    pll_locked <= 1'b1;
    repeat (4) @(posedge clk);
    chk(clock_ready, 1);
    rd(`OSC_STATUS_ADDR);
    chk(rd_data, 32'h600);
    rd(`RC_TUNING_ADDR);
    chk(rd_data, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      config_bits <= '{i < 4 ? 3'h0 : `SRC_PRIMARY, prim_mode_t'(i[2:1]), i[0]};
      fr = ~(i[2] ^ i[1]);
      repeat (6) @(posedge clk);
      chk({pin_mux.pin1_is_io, pin_mux.pin2_is_io, pin_mux.pin2_clk_out,
           pin_mux.amp_bypass, pin1_oe, pin2_oe, pin2_out},
          {i[2:1] == 2'h3, fr & ~i[0], fr & i[0], i[2:1] == 2'h0, ~fr, ~fr | i[0], 1'b0});
      if (i < 4 || i > 5)
        chk(clock_ready, 0);
    end
    // last setting: oscillator off, pin2 carries the cycle clock
    cycle_clk <= 1'b1;
    repeat (6) @(posedge clk);
    chk({pin2_out, pin2_oe}, 2'h3);
    config_bits.second_pin_function_config <= 1'b0;
    pin2_in <= 1'b1;
    wr(`PIN_IO_ADDR, 32'h3);
    rd(`PIN_IO_ADDR);
    chk(rd_data, 32'h7);
    chk({pin2_out, pin2_oe, pin_mux.pin2_is_io}, 3'h7);
    for (i = 0; i < 8; i++)
    begin
      wr(`AUX_CLOCK_CTRL_ADDR, {16'h0, actl[i]});
      repeat (32) @(posedge clk);
      c0 = aux_rises;
      repeat (640) @(posedge clk);
      c0 = aux_rises - c0;
      chk((c0 - aexp[i]) inside {[-1:1]} ? aexp[i] : c0, aexp[i]);
    end
    give_verdict;
  end
endmodule
